// *** common/tmg_pkg.sv ***
// Package for the gated 16-bit timer/counter: offsets, fields, reset values, types
package tmg_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h0B;
  localparam logic [7:0] ADDR_PERIPH_FLAG = 8'h0C;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h0E;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h0F;
  localparam logic [7:0] ADDR_CONTROL     = 8'h10;
  localparam logic [7:0] ADDR_COMPARATOR  = 8'h1A;
  localparam logic [7:0] ADDR_PERIPH_EN   = 8'h8C;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_TIMER_ON   = 0;
  localparam int CTRL_CLK_SRC    = 1;
  localparam int CTRL_SYNC_DIS   = 2;
  localparam int CTRL_LP_OSC_EN  = 3;
  localparam int CTRL_PRESC_LO   = 4;
  localparam int CTRL_GATE_EN    = 6;
  localparam int CTRL_GATE_INV   = 7;
  localparam int IRQC_PERIPH_EN  = 6;
  localparam int IRQC_GLOBAL_EN  = 7;
  localparam int CMP_GATE_SRC    = 1;
  localparam int FLAG_OVERFLOW   = 0;
  localparam int PEN_OVERFLOW    = 0;

  // ------------------------------------------------------------
  // Reset values and limits
  // ------------------------------------------------------------
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic        GATE_SRC_RESET = 1'b1;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;

  // ------------------------------------------------------------
  // Timing: instruction cycle is the system clock divided by four
  // ------------------------------------------------------------
  localparam int         SYS_CLK_MHZ   = 200;
  localparam int         INSTR_DIV     = 4;
  localparam logic [1:0] INSTR_DIV_END = 2'(INSTR_DIV - 1);

  // ------------------------------------------------------------
  // Input synchroniser channels
  // ------------------------------------------------------------
  localparam int SYN_EXT  = 0;
  localparam int SYN_LP   = 1;
  localparam int SYN_GATE = 2;
  localparam int SYN_CMP  = 3;
  localparam int SYN_N    = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } tmg_bus_t;

  typedef struct packed {
    logic [7:0]             control;
    logic [15:0]            count;
    logic [2:0]             presc;
    logic                   ovf_flag;
    logic                   ovf_en;
    logic                   periph_en;
    logic                   global_en;
    logic                   gate_src;
    logic [SYN_N-1:0][2:0]  syn;
    logic [SYN_N-1:0]       stable;
    logic                   armed;
    logic                   pend;
    logic [1:0]             div;
    logic [7:0]             rdata;
    logic                   irq;
    logic                   wake;
    logic                   osc_forced;
  } tmg_state_t;

  localparam tmg_state_t ST_RESET = '{gate_src: GATE_SRC_RESET, control: CONTROL_RESET, default: '0};

endpackage

// *** design/tmg_timer.sv ***
// Gated 16-bit timer/counter with prescaler, gate and register port
`timescale 1ns/1ps
module tmg_timer
  import tmg_pkg::*;
(
  input  wire logic       clk,
  input  wire tmg_bus_t   bus,
  input  wire logic       rst,
  output logic [7:0]      rdata,
  input  wire logic       ext_count_clock_pin,
  input  wire logic       lp_osc_in,
  input  wire logic       gate_pin,
  input  wire logic       comparator_two_output,
  input  wire logic       internal_oscillator_no_clkout,
  input  wire logic       sleep,
  output logic            irq,
  output logic            wake,
  output logic            osc_pins_forced
);

  tmg_state_t q;
  tmg_state_t n;

  logic       raw_in [SYN_N];
  logic       timer_on;
  logic       ext_sel;
  logic       async_mode;
  logic       lp_osc_on;
  logic       cyc_en;
  logic       src_rise;
  logic       src_fall;
  logic       src_tick;
  logic       gate_active;
  logic       count_en;
  logic [2:0] presc_mask;
  logic       tick;
  logic       wr_low;
  logic       wr_high;
  logic       wr_count;
  logic       ovf_event;

  assign raw_in[SYN_EXT]  = ext_count_clock_pin;
  assign raw_in[SYN_LP]   = lp_osc_in;
  assign raw_in[SYN_GATE] = gate_pin;
  assign raw_in[SYN_CMP]  = comparator_two_output;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    n          = q;
    timer_on   = q.control[CTRL_TIMER_ON];
    ext_sel    = q.control[CTRL_CLK_SRC];
    async_mode = ext_sel && q.control[CTRL_SYNC_DIS];
    lp_osc_on  = q.control[CTRL_LP_OSC_EN] && internal_oscillator_no_clkout;
    wr_low     = bus.we && (bus.addr == ADDR_COUNT_LOW);
    wr_high    = bus.we && (bus.addr == ADDR_COUNT_HIGH);
    wr_count   = wr_low || wr_high;

    // Synchronisers: change accepted when second and third stage agree
    for (int i = 0; i < SYN_N; i++)
    begin
      n.syn[i] = {q.syn[i][1:0], raw_in[i]};
      if (q.syn[i][1] == q.syn[i][2])
      begin
        n.stable[i] = q.syn[i][2];
      end
    end

    // Instruction-cycle enable
    cyc_en = (q.div == INSTR_DIV_END);
    n.div  = cyc_en ? 2'h0 : q.div + 2'h1;

    // External source edges, low-power oscillator or pin
    if (lp_osc_on)
    begin
      src_rise = n.stable[SYN_LP] && !q.stable[SYN_LP];
      src_fall = !n.stable[SYN_LP] && q.stable[SYN_LP];
    end
    else
    begin
      src_rise = n.stable[SYN_EXT] && !q.stable[SYN_EXT];
      src_fall = !n.stable[SYN_EXT] && q.stable[SYN_EXT];
    end

    // Falling edge must arm before a rising edge counts
    if (!ext_sel)
    begin
      n.armed = 1'b0;
      n.pend  = 1'b0;
    end
    else if (src_fall)
    begin
      n.armed = 1'b1;
    end

    // Source tick per mode
    src_tick = 1'b0;
    if (!ext_sel)
    begin
      src_tick = cyc_en;
    end
    else if (async_mode)
    begin
      src_tick = src_rise && q.armed;
    end
    else
    begin
      if (src_rise && q.armed)
      begin
        n.pend = 1'b1;
      end
      if (cyc_en && (q.pend || (src_rise && q.armed)))
      begin
        src_tick = 1'b1;
        n.pend   = 1'b0;
      end
    end

    // Gate selection, polarity and enable
    gate_active = (q.gate_src ? q.stable[SYN_CMP] : q.stable[SYN_GATE])
                  ^ q.control[CTRL_GATE_INV];
    count_en    = timer_on
                  && !(q.control[CTRL_GATE_EN] && gate_active)
                  && !(sleep && !async_mode);

    // Prescaler
    presc_mask = 3'((4'h1 << q.control[CTRL_PRESC_LO +: 2]) - 4'h1);
    tick       = 1'b0;
    if (src_tick && count_en)
    begin
      if ((q.presc & presc_mask) == presc_mask)
      begin
        tick    = 1'b1;
        n.presc = 3'h0;
      end
      else
      begin
        n.presc = q.presc + 3'h1;
      end
    end

    // Count and overflow
    ovf_event = 1'b0;
    if (tick)
    begin
      n.count   = q.count + 16'h0001;
      ovf_event = (q.count == COUNT_MAX);
    end
    if (wr_count)
    begin
      n.presc = 3'h0;
      if (wr_low)
      begin
        n.count[7:0] = bus.wdata;
      end
      else
      begin
        n.count[15:8] = bus.wdata;
      end
      ovf_event = 1'b0;
    end

    // Register writes
    if (bus.we)
    begin
      case (bus.addr)
        ADDR_CONTROL:     n.control   = bus.wdata;
        ADDR_PERIPH_FLAG: n.ovf_flag  = bus.wdata[FLAG_OVERFLOW];
        ADDR_PERIPH_EN:   n.ovf_en    = bus.wdata[PEN_OVERFLOW];
        ADDR_IRQ_CONTROL:
        begin
          n.periph_en = bus.wdata[IRQC_PERIPH_EN];
          n.global_en = bus.wdata[IRQC_GLOBAL_EN];
        end
        ADDR_COMPARATOR:  n.gate_src  = bus.wdata[CMP_GATE_SRC];
        default:          n.control   = q.control;
      endcase
    end
    if (ovf_event)
    begin
      n.ovf_flag = 1'b1;
    end

    // Reads: data stands only in the cycle after the strobe
    n.rdata = 8'h00;
    if (bus.re)
    begin
      case (bus.addr)
        ADDR_CONTROL:     n.rdata = q.control;
        ADDR_COUNT_LOW:   n.rdata = q.count[7:0];
        ADDR_COUNT_HIGH:  n.rdata = q.count[15:8];
        ADDR_PERIPH_FLAG: n.rdata = 8'(q.ovf_flag) << FLAG_OVERFLOW;
        ADDR_PERIPH_EN:   n.rdata = 8'(q.ovf_en) << PEN_OVERFLOW;
        ADDR_IRQ_CONTROL: n.rdata = (8'(q.periph_en) << IRQC_PERIPH_EN)
                                    | (8'(q.global_en) << IRQC_GLOBAL_EN);
        ADDR_COMPARATOR:  n.rdata = 8'(q.gate_src) << CMP_GATE_SRC;
        default:          n.rdata = 8'h00;
      endcase
    end

    // Outputs
    n.irq        = q.ovf_flag && q.ovf_en && q.periph_en && q.global_en;
    n.wake       = q.ovf_flag && q.ovf_en && q.periph_en;
    n.osc_forced = lp_osc_on;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= ST_RESET;
    end
    else
    begin
      q <= n;
    end
  end

  assign rdata           = q.rdata;
  assign irq             = q.irq;
  assign wake            = q.wake;
  assign osc_pins_forced = q.osc_forced;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ovf_sets_flag_a: assert property (tick && !wr_count && q.count == COUNT_MAX
    |=> q.ovf_flag && q.count == COUNT_ZERO)
    else $error("overflow did not wrap count and set flag");

  irq_enables_a: assert property (##1 irq == $past(q.ovf_flag && q.ovf_en && q.periph_en && q.global_en))
    else $error("interrupt output not the and of flag and enables");

  flag_sticky_a: assert property (q.ovf_flag && !(bus.we && bus.addr == ADDR_PERIPH_FLAG)
    |=> q.ovf_flag)
    else $error("overflow flag cleared without a software write");

  instr_rate_a: assert property (tick && !ext_sel |-> q.div == INSTR_DIV_END)
    else $error("internal count off the instruction cycle");

  arm_first_a: assert property (src_tick && ext_sel |-> q.armed || q.pend)
    else $error("external count before a falling edge");

  presc_ratio_a: assert property (src_tick && count_en && !wr_count
    && q.control[CTRL_PRESC_LO +: 2] == 2'h3 && q.presc != 3'h7 |=> $stable(q.count))
    else $error("1:8 prescale ticked early");

  presc_clear_a: assert property (wr_count |=> q.presc == 3'h0)
    else $error("count write left prescaler set");

  gate_block_a: assert property (timer_on && q.control[CTRL_GATE_EN] && gate_active && !wr_count
    |=> $stable(q.count) && $stable(q.presc))
    else $error("count moved while gate active");

  off_hold_a: assert property (!timer_on && !wr_count |=> $stable(q.count))
    else $error("count moved with timer off");

  sleep_hold_a: assert property (sleep && !async_mode && !wr_count |=> $stable(q.count))
    else $error("synchronous count moved during sleep");

  osc_force_a: assert property (##1 osc_pins_forced == $past(lp_osc_on))
    else $error("oscillator pin override wrong");

  read_lat_a: assert property (bus.re && bus.addr == ADDR_COUNT_LOW
    |=> rdata == $past(q.count[7:0]))
    else $error("low count byte read wrong");

  read_high_a: assert property (bus.re && bus.addr == ADDR_COUNT_HIGH
    |=> rdata == $past(q.count[15:8]))
    else $error("high count byte read wrong");

  carry_low_a: assert property (tick && !wr_count && q.count[7:0] == 8'hFF
    |=> q.count[15:8] == $past(q.count[15:8]) + 8'h01)
    else $error("low byte wrap did not carry into high byte");

  write_low_a: assert property (wr_low |=> q.count[7:0] == $past(bus.wdata))
    else $error("low count byte write lost");

  write_high_a: assert property (wr_high |=> q.count[15:8] == $past(bus.wdata))
    else $error("high count byte write lost");

  flag_clear_a: assert property (bus.we && bus.addr == ADDR_PERIPH_FLAG
    && !bus.wdata[FLAG_OVERFLOW] && !ovf_event |=> !q.ovf_flag)
    else $error("software write of zero did not clear flag");

  no_flag_quiet_a: assert property (!q.ovf_flag |=> !irq && !wake)
    else $error("interrupt or wake without overflow flag");

  arm_clear_a: assert property (!ext_sel |=> !q.armed)
    else $error("edge arming kept with internal clock");

  async_edge_a: assert property (async_mode && src_rise && q.armed |-> src_tick)
    else $error("asynchronous rising edge not passed on");

  sync_wait_a: assert property (ext_sel && !async_mode && src_tick |-> cyc_en)
    else $error("synchronised count off the instruction cycle");

  gate_source_a: assert property (timer_on && q.control[CTRL_GATE_EN] && !q.control[CTRL_GATE_INV]
    && q.gate_src && q.stable[SYN_CMP] && !q.stable[SYN_GATE] |-> !count_en)
    else $error("comparator gate not obeyed");

  gate_invert_a: assert property (timer_on && !sleep && q.control[CTRL_GATE_EN]
    && ((q.gate_src ? q.stable[SYN_CMP] : q.stable[SYN_GATE]) == q.control[CTRL_GATE_INV]) |-> count_en)
    else $error("inverted gate blocked counting");

  // ------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------
  ovf_c:   cover property (ovf_event);
  gate_c:  cover property (timer_on && q.control[CTRL_GATE_EN] && gate_active && src_tick);
  async_c: cover property (async_mode && tick);
  wake_c:  cover property (wake && sleep);
  presc_c: cover property (tick && q.control[CTRL_PRESC_LO +: 2] == 2'h3);

endmodule // tmg_timer

// *** sim/testbench.sv ***
// Self-checking bench for the gated 16-bit timer/counter
`timescale 1ns/1ps
module testbench
  import tmg_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  tmg_bus_t    bus = '0;
  logic [7:0]  rdata;
  logic        ext_pin, gate_pin, cmp_out, busy, irq, wake, forced;
  logic        start = 1'b0;
  logic [7:0]  n_pulses = 8'h00;
  logic        gate_level = 1'b0;
  logic        cmp_level = 1'b0;
  logic        int_osc_only = 1'b0;
  logic        lp_level = 1'b0;
  logic        sleep = 1'b0;
  logic [31:0] lfsr = 32'hB0CCCB03;
  int          err_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n;
  logic [7:0]  d;
  logic [15:0] c, v;

  tmg_timer u_dut (.clk(clk), .bus(bus), .rst(rst), .rdata(rdata), .ext_count_clock_pin(ext_pin),
    .lp_osc_in(lp_level), .gate_pin(gate_pin), .comparator_two_output(cmp_out),
    .internal_oscillator_no_clkout(int_osc_only),
    .sleep(sleep), .irq(irq), .wake(wake), .osc_pins_forced(forced));
  tmg_far_model u_far (.clk(clk), .start(start), .n_pulses(n_pulses), .gate_level(gate_level),
    .cmp_level(cmp_level), .ext_pin(ext_pin), .gate_pin(gate_pin), .cmp_out(cmp_out), .busy(busy));

  // ------------------------------------------------------------
  // Clock, timeout, helpers
  // ------------------------------------------------------------
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] rnd8();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic int span(input int p, input int k);
    return INSTR_DIV * (1 << p) * k;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    bus <= '{addr: a, wdata: w, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 r = rdata;
  endtask
  task automatic set_count(input logic [15:0] w);
    wr(ADDR_COUNT_LOW, w[7:0]);
    wr(ADDR_COUNT_HIGH, w[15:8]);
  endtask
  task automatic rd16(output logic [15:0] r);
    rd(ADDR_COUNT_LOW, r[7:0]);
    rd(ADDR_COUNT_HIGH, r[15:8]);
  endtask
  task automatic run(input logic [7:0] ctl, input int w);
    wr(ADDR_CONTROL, ctl);
    repeat (w - 2) @(posedge clk);
    wr(ADDR_CONTROL, ctl & 8'hFE);
  endtask
  task automatic check8(input string what, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic check_rng(input string what, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] s);
    n_checks++;
    if ((s >= lo && s <= hi) !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h..%h seen %h", what, lo, hi, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CONTROL, d);
    check8("control reset", CONTROL_RESET, d);
    rd(ADDR_COMPARATOR, d);
    check8("gate source reset", 8'h02, d & 8'h02);
    rd(8'h55, d);
    check8("unmapped", 8'h00, d);
    repeat (4)
    begin
      v = {rnd8(), rnd8()};
      set_count(v);
      repeat (20) @(posedge clk);
      rd16(c);
      check_rng("count held", v, v, c);
    end
    for (int p = 0; p < 4; p++)
    begin
      n = 4 + (rnd8() & 8'h0F);
      run({2'b00, 2'(p), 4'h1}, 4);
      set_count(COUNT_ZERO);
      run({2'b00, 2'(p), 4'h1}, span(p, n) - INSTR_DIV);
      rd16(c);
      check_rng("prescale", 16'(n - 1), 16'(n - 1), c);
    end
    for (int g = 0; g < 16; g++)
    begin
      gate_level <= g[1] ^ g[0];
      cmp_level <= g[1] ^ ~g[0];
      wr(ADDR_COMPARATOR, {6'h00, g[0], 1'b0});
      set_count(COUNT_ZERO);
      run({g[2], g[3], 6'h01}, 64);
      rd16(c);
      if (g[3] && (g[1] ^ g[2]))
        check_rng("gated", 16'h0000, 16'h0000, c);
      else
        check_rng("ungated", 16'h000F, 16'h0011, c);
    end
    set_count(COUNT_ZERO);
    wr(ADDR_PERIPH_FLAG, 8'h00);
    wr(ADDR_PERIPH_EN, 8'h01);
    wr(ADDR_IRQ_CONTROL, 8'hC0);
    check8("irq idle", 8'h00, {7'h00, irq});
    set_count(16'hFFFD);
    run(8'h01, 40);
    rd16(c);
    check_rng("wrap", 16'h0006, 16'h0008, c);
    rd(ADDR_PERIPH_FLAG, d);
    check8("flag set", 8'h01, d & 8'h01);
    check8("irq", 8'h03, {6'h00, irq, wake});
    wr(ADDR_IRQ_CONTROL, 8'h40);
    repeat (20) @(posedge clk);
    rd(ADDR_PERIPH_FLAG, d);
    check8("flag sticks", 8'h01, d & 8'h01);
    check8("irq masked", 8'h01, {6'h00, irq, wake});
    wr(ADDR_PERIPH_FLAG, 8'h00);
    rd(ADDR_PERIPH_FLAG, d);
    check8("flag clear", 8'h00, d & 8'h01);
    check8("wake off", 8'h00, {6'h00, irq, wake});
    for (int m = 0; m < 3; m++)
    begin
      wr(ADDR_CONTROL, 8'h00);
      set_count(COUNT_ZERO);
      sleep <= (m != 1);
      wr(ADDR_CONTROL, {5'h00, m == 0, 2'b11});
      n = 3 + (rnd8() & 8'h07);
      n_pulses <= 8'(n);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 4000 && busy; k++) @(posedge clk);
      repeat (16) @(posedge clk);
      wr(ADDR_CONTROL, 8'h00);
      sleep <= 1'b0;
      rd16(c);
      v = (m == 2) ? COUNT_ZERO : 16'(n - 1);
      check_rng("ext count", v, v, c);
    end
    wr(ADDR_CONTROL, 8'h08);
    repeat (4) @(posedge clk);
    check8("osc ignored", 8'h00, {7'h00, forced});
    int_osc_only <= 1'b1;
    repeat (4) @(posedge clk);
    check8("osc forced", 8'h01, {7'h00, forced});
    set_count(COUNT_ZERO);
    wr(ADDR_CONTROL, 8'h0F);
    for (int k = 0; k < 5; k++)
    begin
      lp_level <= 1'b1;
      repeat (8) @(posedge clk);
      lp_level <= 1'b0;
      repeat (8) @(posedge clk);
    end
    wr(ADDR_CONTROL, 8'h08);
    rd16(c);
    check_rng("lp osc count", 16'h0004, 16'h0004, c);
    tally_and_finish();
  end
endmodule // testbench

// *** sim/tmg_far_model.sv ***
// Far-side model: count clock pin, gate pin, comparator output
`timescale 1ns/1ps
module tmg_far_model
  import tmg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [7:0] n_pulses,
  input  wire logic       gate_level,
  input  wire logic       cmp_level,
  output logic            ext_pin,
  output logic            gate_pin,
  output logic            cmp_out,
  output logic            busy
);
  logic [11:0] cnt_reg = 12'h000;
  assign gate_pin = gate_level;
  assign cmp_out  = cmp_level;
  assign busy     = (cnt_reg != 12'h000);
  // Pulses 8 clocks high, 8 low, idle low
  assign ext_pin  = busy & cnt_reg[3];
  always_ff @(posedge clk)
  begin
    if (start)
      cnt_reg <= {n_pulses, 4'h0};
    else if (busy)
      cnt_reg <= cnt_reg - 12'h001;
  end
endmodule // tmg_far_model
